// ---- core/afs_fault_status.sv ----
`timescale 1ns/10ps
module afs_fault_status
  import afs_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_SYS_IN,
  input  wire logic       NRST_IN,
  // Register port
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  output logic      [7:0] REG_RDATA_OUT,
  // Fault events
  input  wire logic       LEFT_DC_DET_IN,
  input  wire logic       RIGHT_DC_DET_IN,
  input  wire logic       LEFT_OC_DET_IN,
  input  wire logic       RIGHT_OC_DET_IN,
  input  wire logic       OTP_CRC_FAIL_IN,
  input  wire logic       BIQUAD_WR_FAIL_IN,
  input  wire logic       BIQUAD_WR_OK_IN,
  input  wire logic       EEPROM_LOAD_DONE_IN,
  input  wire logic       EEPROM_LOAD_FAIL_IN,
  // Fault reporting
  output logic            POWER_HIZ_OUT,
  output logic            FAULT_OUT
);

  logic [3:0] chan_r;
  logic [3:0] chan_nxt;
  logic       otp_crc_r;
  logic       otp_crc_nxt;
  logic       biquad_write_failed_r;
  logic       biquad_write_failed_nxt;
  logic       eeprom_r;
  logic       eeprom_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       clear_wr;
  logic [3:0] chan_set;

  assign clear_wr = REG_WR_IN && (REG_ADDR_IN == FAULT_CLEAR_OFS)
                    && REG_WDATA_IN[FAULT_CLEAR_BIT];

  always_comb begin
    chan_set               = '0;
    chan_set[LEFT_DC_BIT]  = LEFT_DC_DET_IN;
    chan_set[RIGHT_DC_BIT] = RIGHT_DC_DET_IN;
    chan_set[LEFT_OC_BIT]  = LEFT_OC_DET_IN;
    chan_set[RIGHT_OC_BIT] = RIGHT_OC_DET_IN;
    // Set wins over a clear in the same cycle
    chan_nxt = (clear_wr ? 4'h0 : chan_r) | chan_set;
    // Of the global bits, only the OTP CRC bit is sticky and cleared by the clear register; BIQUAD and EEPROM bits ignore it
    otp_crc_nxt = (clear_wr ? 1'b0 : otp_crc_r) | OTP_CRC_FAIL_IN;
    // Tracks most recent write outcome
    biquad_write_failed_nxt = biquad_write_failed_r;
    if (BIQUAD_WR_FAIL_IN) begin
      biquad_write_failed_nxt = 1'b1;
    end else if (BIQUAD_WR_OK_IN) begin
      biquad_write_failed_nxt = 1'b0;
    end
    eeprom_nxt = eeprom_r;
    if (EEPROM_LOAD_DONE_IN) begin
      eeprom_nxt = EEPROM_LOAD_FAIL_IN;
    end
    // Status registers are read-only; only the clear register writes
    rdata_nxt = 8'h00;
    unique case (REG_ADDR_IN)
      CHANNEL_FAULT_STATUS_OFS: begin
        rdata_nxt = {4'h0, chan_r};
      end
      GLOBAL_FAULT_STATUS_ONE_OFS: begin
        rdata_nxt = {otp_crc_r, biquad_write_failed_r, eeprom_r, 5'h00};
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      chan_r                <= CHANNEL_FAULT_STATUS_RST[3:0];
      otp_crc_r             <= GLOBAL_FAULT_STATUS_ONE_RST[OTP_CRC_BIT];
      biquad_write_failed_r <= GLOBAL_FAULT_STATUS_ONE_RST[BIQUAD_BIT];
      eeprom_r              <= GLOBAL_FAULT_STATUS_ONE_RST[EEPROM_BIT];
      rdata_r               <= 8'h00;
    end else begin
      chan_r                <= chan_nxt;
      otp_crc_r             <= otp_crc_nxt;
      biquad_write_failed_r <= biquad_write_failed_nxt;
      eeprom_r              <= eeprom_nxt;
      rdata_r               <= rdata_nxt;
    end
  end

  assign REG_RDATA_OUT = rdata_r;
  // Direct from flags so output shuts off the cycle after the event
  assign POWER_HIZ_OUT = |chan_r;
  assign FAULT_OUT     = |chan_r;

  // Assertions
  property p_dc_set;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      LEFT_DC_DET_IN |=> chan_r[LEFT_DC_BIT];
  endproperty
  a_dc_set: assert property (p_dc_set)
    else $error("left dc flag not set");

  property p_oc_set;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      RIGHT_OC_DET_IN |=> chan_r[RIGHT_OC_BIT];
  endproperty
  a_oc_set: assert property (p_oc_set)
    else $error("right oc flag not set");

  property p_hiz;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      (LEFT_OC_DET_IN || RIGHT_DC_DET_IN) |=> POWER_HIZ_OUT;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("power stage not hi-z");

  property p_fault_pin;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      (|chan_set) |=> FAULT_OUT;
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin not raised");

  property p_hold;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      (chan_r[LEFT_DC_BIT] && !clear_wr) |=> chan_r[LEFT_DC_BIT];
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped without clear");

  property p_clear;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      (clear_wr && chan_set == 4'h0) |=> (chan_r == 4'h0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not clear");

  property p_otp;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      OTP_CRC_FAIL_IN |=> otp_crc_r;
  endproperty
  a_otp: assert property (p_otp)
    else $error("otp flag not set");

  property p_bq;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      BIQUAD_WR_FAIL_IN |=> biquad_write_failed_r;
  endproperty
  a_bq: assert property (p_bq)
    else $error("biquad flag not set");

  property p_eeprom;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      EEPROM_LOAD_DONE_IN |=> (eeprom_r == $past(EEPROM_LOAD_FAIL_IN));
  endproperty
  a_eeprom: assert property (p_eeprom)
    else $error("eeprom bit wrong");

  property p_resv;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      ($past(REG_ADDR_IN) == CHANNEL_FAULT_STATUS_OFS)
        |-> (REG_RDATA_OUT[7:4] == 4'h0);
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits nonzero");

  property p_ro;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      (REG_WR_IN && REG_ADDR_IN == CHANNEL_FAULT_STATUS_OFS
       && chan_set == 4'h0) |=> (chan_r == $past(chan_r));
  endproperty
  a_ro: assert property (p_ro)
    else $error("status write took effect");

  property p_dc_right;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      RIGHT_DC_DET_IN |=> chan_r[RIGHT_DC_BIT];
  endproperty
  a_dc_right: assert property (p_dc_right)
    else $error("right dc flag not set");

  property p_oc_left;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      LEFT_OC_DET_IN |=> chan_r[LEFT_OC_BIT];
  endproperty
  a_oc_left: assert property (p_oc_left)
    else $error("left oc flag not set");

  // Pin must drop once a clear empties every flag
  property p_fault_off;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      (clear_wr && chan_set == 4'h0) |=> (!FAULT_OUT && !POWER_HIZ_OUT);
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault pin stuck after clear");

  property p_otp_hold;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      (otp_crc_r && !clear_wr) |=> otp_crc_r;
  endproperty
  a_otp_hold: assert property (p_otp_hold)
    else $error("otp flag dropped without clear");

  // Fail wins when both outcomes arrive together
  property p_bq_ok;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      (BIQUAD_WR_OK_IN && !BIQUAD_WR_FAIL_IN) |=> !biquad_write_failed_r;
  endproperty
  a_bq_ok: assert property (p_bq_ok)
    else $error("biquad flag kept after good write");

  property p_resv_glob;
    @(posedge CLK_SYS_IN) disable iff (!NRST_IN)
      ($past(REG_ADDR_IN) == GLOBAL_FAULT_STATUS_ONE_OFS)
        |-> (REG_RDATA_OUT[4:0] == 5'h00);
  endproperty
  a_resv_glob: assert property (p_resv_glob)
    else $error("global reserved bits nonzero");

  // No disable here: this one watches the reset itself
  property p_rst;
    @(posedge CLK_SYS_IN)
      !NRST_IN |=> (chan_r == 4'h0 && !otp_crc_r && !eeprom_r
                    && !biquad_write_failed_r && REG_RDATA_OUT == 8'h00);
  endproperty
  a_rst: assert property (p_rst)
    else $error("flags not cleared by reset");

  c_dc: cover property (@(posedge CLK_SYS_IN) LEFT_DC_DET_IN ##1 FAULT_OUT);
  c_clear: cover property (@(posedge CLK_SYS_IN) FAULT_OUT ##1 clear_wr
                           ##1 !FAULT_OUT);
  c_race: cover property (@(posedge CLK_SYS_IN) clear_wr && chan_set != 4'h0);
  c_eep: cover property (@(posedge CLK_SYS_IN)
                         EEPROM_LOAD_DONE_IN && EEPROM_LOAD_FAIL_IN);

endmodule : afs_fault_status

// ---- core/afs_pkg.sv ----
package afs_pkg;
  // Register offsets
  localparam logic [7:0] CHANNEL_FAULT_STATUS_OFS    = 8'h70;
  localparam logic [7:0] GLOBAL_FAULT_STATUS_ONE_OFS = 8'h71;
  localparam logic [7:0] FAULT_CLEAR_OFS             = 8'h78;
  // Reset values
  localparam logic [7:0] CHANNEL_FAULT_STATUS_RST    = 8'h00;
  localparam logic [7:0] GLOBAL_FAULT_STATUS_ONE_RST = 8'h00;
  // Channel fault bit positions
  localparam int LEFT_DC_BIT    = 3;
  localparam int RIGHT_DC_BIT   = 2;
  localparam int LEFT_OC_BIT    = 1;
  localparam int RIGHT_OC_BIT   = 0;
  // Global fault one bit positions
  localparam int OTP_CRC_BIT    = 7;
  localparam int BIQUAD_BIT     = 6;
  localparam int EEPROM_BIT     = 5;
  // Fault clear bit
  localparam int FAULT_CLEAR_BIT = 7;
endpackage : afs_pkg

// ---- dv/afs_fault_status_test.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  err_total++; $display("ERROR t=%0t got %h exp %h", $time, a, e); \
  end end
module afs_fault_status_test
  import afs_pkg::*;
;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic       wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [8:0] ev = 9'h000;
  logic [7:0] rdata;
  logic       hiz;
  logic       flt;
  int         err_total = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  always #50 clk = ~clk;
  afs_fault_status uut (
    .CLK_SYS_IN          (clk),
    .NRST_IN             (nrst),
    .REG_ADDR_IN         (addr),
    .REG_WR_IN           (wr),
    .REG_WDATA_IN        (wdata),
    .REG_RDATA_OUT       (rdata),
    .LEFT_DC_DET_IN      (ev[0]),
    .RIGHT_DC_DET_IN     (ev[1]),
    .LEFT_OC_DET_IN      (ev[2]),
    .RIGHT_OC_DET_IN     (ev[3]),
    .OTP_CRC_FAIL_IN     (ev[4]),
    .BIQUAD_WR_FAIL_IN   (ev[5]),
    .BIQUAD_WR_OK_IN     (ev[6]),
    .EEPROM_LOAD_DONE_IN (ev[7]),
    .EEPROM_LOAD_FAIL_IN (ev[8]),
    .POWER_HIZ_OUT       (hiz),
    .FAULT_OUT           (flt)
  );
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1;
    `CHK(rdata, e)
  endtask : rd_reg
  task pulse(input logic [8:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 9'h000;
    #1;
  endtask : pulse
  // Ceiling well above the roughly 130 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(CHANNEL_FAULT_STATUS_OFS, CHANNEL_FAULT_STATUS_RST);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'h00);
    `CHK(flt, 1'b0)
    `CHK(hiz, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      pulse(9'h001 << i);
      `CHK(hiz, 1'b1)
      `CHK(flt, 1'b1)
      rd_reg(CHANNEL_FAULT_STATUS_OFS, 8'h08 >> i);
      wr_reg(CHANNEL_FAULT_STATUS_OFS, 8'hFF);
      rd_reg(CHANNEL_FAULT_STATUS_OFS, 8'h08 >> i);
      // Clear bit low: flags must hold
      wr_reg(FAULT_CLEAR_OFS, 8'h7F);
      rd_reg(CHANNEL_FAULT_STATUS_OFS, 8'h08 >> i);
      `CHK(hiz, 1'b1)
      wr_reg(FAULT_CLEAR_OFS, 8'h80);
      `CHK(flt, 1'b0)
      `CHK(hiz, 1'b0)
      rd_reg(CHANNEL_FAULT_STATUS_OFS, 8'h00);
    end
    // Set and clear in one cycle: set must win
    @(posedge clk);
    ev <= 9'h002;
    addr <= FAULT_CLEAR_OFS;
    wdata <= 8'h80;
    wr <= 1'b1;
    @(posedge clk);
    ev <= 9'h000;
    wr <= 1'b0;
    rd_reg(CHANNEL_FAULT_STATUS_OFS, 8'h04);
    `CHK(flt, 1'b1)
    wr_reg(FAULT_CLEAR_OFS, 8'h80);
    `CHK(flt, 1'b0)
    $display("test channel done");
    pulse(9'h010);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'h80);
    pulse(9'h020);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'hC0);
    wr_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'hFF);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'hC0);
    pulse(9'h040);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'h80);
    pulse(9'h060);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'hC0);
    pulse(9'h180);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'hE0);
    pulse(9'h100);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'hE0);
    pulse(9'h080);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'hC0);
    pulse(9'h040);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'h80);
    wr_reg(FAULT_CLEAR_OFS, 8'h80);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'h00);
    rd_reg(8'h55, 8'h00);
    $display("test global done");
    // Reset in mid-run must drop every flag
    pulse(9'h1BF);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'hE0);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    `CHK(flt, 1'b0)
    `CHK(hiz, 1'b0)
    rd_reg(CHANNEL_FAULT_STATUS_OFS, 8'h00);
    rd_reg(GLOBAL_FAULT_STATUS_ONE_OFS, 8'h00);
    $display("test reset again done");
    finish_test();
  end
endmodule : afs_fault_status_test
